/* File: core/hpsd_pkg.sv */
// Constants shared by the host port strap decoder.
package hpsd_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFF_USER_BAUD = 8'h00;
  localparam logic [7:0] OFF_CHAIN_MODE = 8'h04;
  localparam logic [7:0] OFF_HOST_CMD = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_BAUD_NOW = 8'h10;
  // Status register field positions.
  localparam int ST_ID_LSB = 0;
  localparam int ST_FIXED_BIT = 6;
  localparam int ST_RS485_BIT = 7;
  localparam int ST_ADDR_BIT = 8;
  localparam int ST_READY_BIT = 9;
  // Clock rate and baud figures.
  localparam int CLK_HZ = 10000000;
  localparam int FIXED_BAUD = 9600;
  localparam logic [15:0] FIXED_DIV = 16'((CLK_HZ + FIXED_BAUD / 2) / FIXED_BAUD);
  // Values after reset.
  localparam logic [15:0] USER_DIV_RST = 16'h0411;
  localparam logic [1:0] CHAIN_MODE_RST = 2'h0;
  // Cycles from reset release until the synchronised straps are trusted.
  localparam logic [2:0] SETTLE_CYCLES = 3'h4;
  // Prompt character returned after each accepted host command.
  localparam logic [7:0] PROMPT_CHAR = 8'h3e;
  // Identifier width and offset.
  localparam int ID_BITS = 5;
  localparam logic [5:0] ID_BASE = 6'h01;
  typedef enum logic [1:0] {HPSD_WAIT, HPSD_SAMPLE, HPSD_RUN} hpsd_phase_t;
endpackage

/* File: core/hpsd_top.sv */
// Host port strap decoder with APB register access.
// How it works
// - Reset samples baud switch, sets host rate.
// - User position takes configured rate register.
// - Fixed position forces 9600, ignores configuration.
// - Identifier is the uninverted switch code plus one.
// - Identifier switches latched only at power-up.
// - Mode switch selects RS-232 or RS-485 port.
// - Prompt character follows every accepted host command.
// - Chain mode command selects chained communication mode.
//
// The APB slave port and the register addresses were decided locally.
module hpsd_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic porn,
  input wire logic ce,
  input wire logic baudFixedPin,
  input wire logic rs485Pin,
  input wire logic [4:0] idSelectPins,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frameAddrValid,
  input wire logic [5:0] frameAddr,
  input wire logic txActive,
  output logic [15:0] baudDiv,
  output logic rs485Mode,
  output logic [5:0] unitId,
  output logic [1:0] chainMode,
  output logic promptValid,
  output logic [7:0] promptData,
  output logic txDriveEn
);
  typedef struct packed {
    logic [1:0] fixedSync;
    logic [1:0] rs485Sync;
    logic [9:0] idSync;
    logic [2:0] settle;
    hpsd_pkg::hpsd_phase_t phase;
    logic baudFixed;
    logic rs485;
    logic [15:0] userDiv;
    logic [15:0] baudDiv;
    logic [1:0] chainMode;
    logic addressed;
    logic promptValid;
    logic [7:0] promptData;
    logic [31:0] prdata;
  } hpsd_state_t;

  hpsd_state_t st_r;
  hpsd_state_t st_nxt;
  logic idTaken_r;
  logic [4:0] idCode_r;
  logic apbAccess;
  logic apbWrite;
  logic apbRead;
  logic mapped;
  logic [5:0] idNow;

  // The bus answers in the access cycle; a frozen block holds the master off.
  assign pready = ce;
  assign apbAccess = psel && penable && ce;
  assign apbWrite = apbAccess && pwrite;
  assign apbRead = apbAccess && !pwrite;
  assign mapped = (paddr == hpsd_pkg::OFF_USER_BAUD) || (paddr == hpsd_pkg::OFF_CHAIN_MODE) ||
                  (paddr == hpsd_pkg::OFF_HOST_CMD) || (paddr == hpsd_pkg::OFF_STATUS) ||
                  (paddr == hpsd_pkg::OFF_BAUD_NOW);
  assign pslverr = psel && penable && !mapped;

  // switch code plus one, not inverted
  // An OFF switch reads high on its pull-up and counts as a one.
  assign idNow = {1'b0, idCode_r} + hpsd_pkg::ID_BASE;

  // Next-state logic for everything except the identifier latch.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.promptValid = 1'b0;
    // Two flip-flops per strap before anything reads them.
    st_nxt.fixedSync = {st_r.fixedSync[0], baudFixedPin};
    st_nxt.rs485Sync = {st_r.rs485Sync[0], rs485Pin};
    st_nxt.idSync = {st_r.idSync[4:0], idSelectPins};
    unique case (st_r.phase)
      hpsd_pkg::HPSD_WAIT:
      begin
        if (st_r.settle == hpsd_pkg::SETTLE_CYCLES)
        begin
          st_nxt.phase = hpsd_pkg::HPSD_SAMPLE;
        end
        else
        begin
          st_nxt.settle = st_r.settle + 3'h1;
        end
      end
      hpsd_pkg::HPSD_SAMPLE:
      begin
        st_nxt.baudFixed = st_r.fixedSync[1];
        st_nxt.rs485 = st_r.rs485Sync[1];
        st_nxt.phase = hpsd_pkg::HPSD_RUN;
      end
      hpsd_pkg::HPSD_RUN:
      begin
        st_nxt.phase = hpsd_pkg::HPSD_RUN;
      end
    endcase
    st_nxt.baudDiv = st_nxt.baudFixed ? hpsd_pkg::FIXED_DIV : st_nxt.userDiv;
    // Register writes.
    if (apbWrite)
    begin
      if (paddr == hpsd_pkg::OFF_USER_BAUD)
      begin
        st_nxt.userDiv = pwdata[15:0];
      end
      if (paddr == hpsd_pkg::OFF_CHAIN_MODE)
      begin
        st_nxt.chainMode = pwdata[1:0];
      end
      if (paddr == hpsd_pkg::OFF_HOST_CMD)
      begin
        st_nxt.promptValid = 1'b1;
        st_nxt.promptData = hpsd_pkg::PROMPT_CHAR;
      end
    end
    // track addressed state
    // In RS-485 mode the driver stays off until a frame names this unit.
    if (frameAddrValid && st_r.phase == hpsd_pkg::HPSD_RUN && idTaken_r)
    begin
      st_nxt.addressed = (frameAddr == idNow);
    end
    // Read data is registered in the setup cycle, valid in the access cycle.
    st_nxt.prdata = 32'h0;
    if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        hpsd_pkg::OFF_USER_BAUD: st_nxt.prdata = {16'h0, st_r.userDiv};
        hpsd_pkg::OFF_CHAIN_MODE: st_nxt.prdata = {30'h0, st_r.chainMode};
        hpsd_pkg::OFF_STATUS:
        begin
          st_nxt.prdata[hpsd_pkg::ST_ID_LSB +: 6] = idTaken_r ? idNow : 6'h0;
          st_nxt.prdata[hpsd_pkg::ST_FIXED_BIT] = st_r.baudFixed;
          st_nxt.prdata[hpsd_pkg::ST_RS485_BIT] = st_r.rs485;
          st_nxt.prdata[hpsd_pkg::ST_ADDR_BIT] = st_r.addressed;
          st_nxt.prdata[hpsd_pkg::ST_READY_BIT] = (st_r.phase == hpsd_pkg::HPSD_RUN);
        end
        hpsd_pkg::OFF_BAUD_NOW: st_nxt.prdata = {16'h0, st_r.baudDiv};
        default: st_nxt.prdata = 32'h0;
      endcase
    end
  end

  // Main state register; the clock enable freezes everything.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= '0;
      st_r.userDiv <= hpsd_pkg::USER_DIV_RST;
      st_r.chainMode <= hpsd_pkg::CHAIN_MODE_RST;
      st_r.baudDiv <= hpsd_pkg::USER_DIV_RST;
      st_r.phase <= hpsd_pkg::HPSD_WAIT;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  // latch identifier once
  // Only a power-on reset clears this; a plain reset keeps the identifier,
  // so moving the switches later has no effect until power cycles.
  always_ff @(posedge clk or negedge porn)
  begin
    if (!porn)
    begin
      idTaken_r <= 1'b0;
      idCode_r <= 5'h00;
    end
    else if (ce && !idTaken_r && st_r.phase == hpsd_pkg::HPSD_SAMPLE)
    begin
      idTaken_r <= 1'b1;
      idCode_r <= st_r.idSync[9:5];
    end
  end

  // Outputs.
  assign prdata = st_r.prdata;
  assign baudDiv = st_r.baudDiv;
  assign rs485Mode = st_r.rs485;
  assign unitId = idTaken_r ? idNow : 6'h0;
  assign chainMode = st_r.chainMode;
  assign promptValid = st_r.promptValid;
  assign promptData = st_r.promptData;
  // gate RS-485 driver
  // RS-232 owns its line alone, so it may drive whenever the port runs.
  assign txDriveEn = (st_r.phase == hpsd_pkg::HPSD_RUN) && txActive &&
                     (!st_r.rs485 || st_r.addressed);

  // Assertions guarding the decoded behaviour.
  a_fixed_rate_forced: assert property (@(posedge clk) disable iff (!rstn)
    st_r.phase == hpsd_pkg::HPSD_RUN && st_r.baudFixed |-> baudDiv == hpsd_pkg::FIXED_DIV)
    else $error("Fixed position did not force the fixed rate.");
  a_user_rate_used: assert property (@(posedge clk) disable iff (!rstn)
    ce && st_r.phase == hpsd_pkg::HPSD_RUN && !st_r.baudFixed && $stable(st_r.userDiv)
    |=> baudDiv == $past(st_r.userDiv))
    else $error("User position did not use the configured rate.");
  a_baud_sampled_once: assert property (@(posedge clk) disable iff (!rstn)
    ce && st_r.phase == hpsd_pkg::HPSD_SAMPLE |=> st_r.baudFixed == $past(st_r.fixedSync[1]))
    else $error("Baud switch not sampled after reset.");
  a_baud_held_run: assert property (@(posedge clk) disable iff (!rstn)
    st_r.phase == hpsd_pkg::HPSD_RUN ##1 st_r.phase == hpsd_pkg::HPSD_RUN |-> $stable(st_r.baudFixed))
    else $error("Baud selection changed while running.");
  a_mode_from_switch: assert property (@(posedge clk) disable iff (!rstn)
    ce && st_r.phase == hpsd_pkg::HPSD_SAMPLE |=> rs485Mode == $past(st_r.rs485Sync[1]))
    else $error("Port mode does not follow the mode switch.");
  a_id_decode: assert property (@(posedge clk) disable iff (!porn)
    idTaken_r |-> unitId == {1'b0, idCode_r} + 6'h01 && unitId >= 6'h01 && unitId <= 6'h20)
    else $error("Identifier decode out of range.");
  a_id_latched: assert property (@(posedge clk) disable iff (!porn)
    idTaken_r ##1 idTaken_r |-> $stable(idCode_r))
    else $error("Identifier changed after power-up latch.");
  a_prompt_after_cmd: assert property (@(posedge clk) disable iff (!rstn)
    apbWrite && paddr == hpsd_pkg::OFF_HOST_CMD |=> promptValid && promptData == 8'h3e)
    else $error("No prompt after an accepted host command.");
  a_chain_mode_write: assert property (@(posedge clk) disable iff (!rstn)
    apbWrite && paddr == hpsd_pkg::OFF_CHAIN_MODE |=> chainMode == $past(pwdata[1:0]))
    else $error("Chain mode command not applied.");
  a_rs485_driver_quiet: assert property (@(posedge clk) disable iff (!rstn)
    rs485Mode && !st_r.addressed |-> !txDriveEn)
    else $error("RS-485 driver enabled while not addressed.");

  // Further guards on the quieter corners of the block.
  // They watch what a short test rarely disturbs: holds, pulses and idle outputs.

  a_prompt_one_cycle: assert property (@(posedge clk) disable iff (!rstn)
    ce && promptValid && !(apbWrite && paddr == hpsd_pkg::OFF_HOST_CMD) |=> !promptValid)
    else $error("Prompt pulse lasted more than one cycle.");

  a_prompt_char: assert property (@(posedge clk) disable iff (!rstn)
    promptValid |-> promptData == hpsd_pkg::PROMPT_CHAR)
    else $error("Prompt pulse carried the wrong character.");

  a_driver_off_idle: assert property (@(posedge clk) disable iff (!rstn)
    !txActive |-> !txDriveEn)
    else $error("Line driver enabled with nothing to send.");

  a_driver_off_early: assert property (@(posedge clk) disable iff (!rstn)
    st_r.phase != hpsd_pkg::HPSD_RUN |-> !txDriveEn)
    else $error("Line driver enabled before the straps were sampled.");

  a_addressed_match: assert property (@(posedge clk) disable iff (!rstn)
    ce && frameAddrValid && st_r.phase == hpsd_pkg::HPSD_RUN && idTaken_r
    |=> st_r.addressed == ($past(frameAddr) == $past(idNow)))
    else $error("Addressed flag does not follow the frame address.");

  a_driver_rs232: assert property (@(posedge clk) disable iff (!rstn)
    !rs485Mode && st_r.phase == hpsd_pkg::HPSD_RUN && txActive |-> txDriveEn)
    else $error("RS-232 port did not drive while sending.");

  a_mode_held_run: assert property (@(posedge clk) disable iff (!rstn)
    st_r.phase == hpsd_pkg::HPSD_RUN ##1 st_r.phase == hpsd_pkg::HPSD_RUN |-> $stable(rs485Mode))
    else $error("Port mode changed while running.");

  a_baud_hold_wait: assert property (@(posedge clk) disable iff (!rstn)
    ce && st_r.phase == hpsd_pkg::HPSD_WAIT |=> $stable(st_r.baudFixed))
    else $error("Baud selection changed before sampling.");

  a_id_zero_early: assert property (@(posedge clk) disable iff (!porn)
    !idTaken_r |-> unitId == 6'h00)
    else $error("Identifier shown before it was latched.");

  a_id_taken_sample: assert property (@(posedge clk) disable iff (!porn)
    ce && !idTaken_r && st_r.phase == hpsd_pkg::HPSD_SAMPLE
    |=> idTaken_r && idCode_r == $past(st_r.idSync[9:5]))
    else $error("Identifier not latched at strap sampling.");

  a_chain_mode_hold: assert property (@(posedge clk) disable iff (!rstn)
    ce && !(apbWrite && paddr == hpsd_pkg::OFF_CHAIN_MODE) |=> $stable(chainMode))
    else $error("Chain mode changed without a command.");

  a_user_div_write: assert property (@(posedge clk) disable iff (!rstn)
    ce && apbWrite && paddr == hpsd_pkg::OFF_USER_BAUD |=> st_r.userDiv == $past(pwdata[15:0]))
    else $error("Configured rate write was not stored.");
endmodule

/* File: test/hpsd_host_model.sv */
// Behavioural host on the chain that sends frame addresses and asks to transmit.
module hpsd_host_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sendReq,
  input wire logic [5:0] sendAddr,
  input wire logic txWant,
  output logic frameAddrValid,
  output logic [5:0] frameAddr,
  output logic txActive
);
  timeunit 1ns;
  timeprecision 1ns;
  // one RS-485 chain.
  // Addresses stay within 1 to 32 and each unit has its own, all at one baud rate.
  // Between frames the address lines flip, so a stale address is never left standing.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      frameAddrValid <= 1'b0;
      frameAddr <= 6'h00;
      txActive <= 1'b0;
    end
    else
    begin
      frameAddrValid <= sendReq;
      frameAddr <= sendReq ? sendAddr : ~frameAddr;
      txActive <= txWant;
    end
  end
endmodule

/* File: test/hpsd_top_tb.sv */
// Self-checking bench for the host port strap decoder.
module hpsd_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, porn = 0, ce = 1, baudFixedPin = 1, rs485Pin = 1;
  logic psel = 0, penable = 0, pwrite = 0, sendReq = 0, txWant = 0;
  logic [4:0] idSelectPins = 5'h00;
  logic [7:0] paddr = 8'h00, promptData;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, frameAddrValid, txActive, rs485Mode, promptValid, txDriveEn;
  logic [5:0] frameAddr, unitId, id, sendAddr = 6'h01;
  logic [15:0] baudDiv;
  logic [1:0] chainMode;
  logic [32:0] expQ[$];
  logic [7:0] prQ[$];
  int mismatches = 0, num_checks = 0, seed;
  hpsd_top dut_u (.clk, .rstn, .porn, .ce, .baudFixedPin, .rs485Pin, .idSelectPins,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .frameAddrValid, .frameAddr, .txActive, .baudDiv, .rs485Mode, .unitId, .chainMode,
    .promptValid, .promptData, .txDriveEn);
  hpsd_host_model host_u (.clk, .rstn, .sendReq, .sendAddr, .txWant, .frameAddrValid,
    .frameAddr, .txActive);
  // The clock runs at 10 MHz.
  initial forever #50 clk = ~clk;
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0 && expQ.size() == 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [32:0] e, input logic [32:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask
  function automatic logic [32:0] status(input logic [5:0] i, input logic f, r, a);
    return {1'b0, 22'h0, 1'b1, a, r, f, i};
  endfunction
  // One APB transfer; reads note their expected {pslverr, prdata} first.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    if (!w)
      expQ.push_back(e);
    if (w && a == hpsd_pkg::OFF_HOST_CMD)
      prQ.push_back(hpsd_pkg::PROMPT_CHAR);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk);
    end
    if (n >= 50)
    begin
      mismatches++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task reset(input logic pw);
    @(posedge clk);
    rstn <= 1'b0;
    porn <= !pw;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    porn <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task send(input logic [5:0] a);
    sendReq <= 1'b1;
    sendAddr <= a;
    @(posedge clk);
    sendReq <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  // Results are matched with the oldest note; an unexpected one compares against x.
  // Sampled at the rising edge that completes the transfer, before it updates anything.
  always @(posedge clk)
  begin
    if (psel && penable && pready && !pwrite)
      chk("read", expQ.size() ? expQ.pop_front() : 'x, {pslverr, prdata});
    if (promptValid === 1'b1)
      chk("prompt", prQ.size() ? 33'(prQ.pop_front()) : 'x, 33'(promptData));
  end
  // A hang anywhere counts as a mismatch and still reaches the report.
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
  initial
  begin
    seed = $urandom(12);
    idSelectPins <= 5'($urandom);
    reset(1'b1);
    id = 6'({1'b0, idSelectPins}) + 6'h01;
    @(negedge clk);
    chk("unitId", 33'(id), 33'(unitId));
    chk("baudDiv", 33'(hpsd_pkg::FIXED_DIV), 33'(baudDiv));
    chk("rs485Mode", 33'h1, 33'(rs485Mode));
    apb(1'b1, hpsd_pkg::OFF_USER_BAUD, 32'h0000_0123, 33'h0);
    apb(1'b0, hpsd_pkg::OFF_BAUD_NOW, 32'h0, 33'(hpsd_pkg::FIXED_DIV));
    apb(1'b0, hpsd_pkg::OFF_USER_BAUD, 32'h0, 33'h0_0000_0123);
    apb(1'b1, hpsd_pkg::OFF_STATUS, 32'hffff_ffff, 33'h0);
    apb(1'b0, hpsd_pkg::OFF_STATUS, 32'h0, status(id, 1'b1, 1'b1, 1'b0));
    apb(1'b0, 8'h14, 32'h0, {1'b1, 32'h0});
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, hpsd_pkg::OFF_CHAIN_MODE, 32'(m), 33'h0);
      apb(1'b0, hpsd_pkg::OFF_CHAIN_MODE, 32'h0, 33'(m));
      chk("chainMode", 33'(m), 33'(chainMode));
    end
    apb(1'b1, hpsd_pkg::OFF_HOST_CMD, 32'h0, 33'h0);
    apb(1'b1, hpsd_pkg::OFF_HOST_CMD, 32'h5, 33'h0);
    txWant <= 1'b1;
    send(6'(id % 32 + 1));
    chk("txDriveEn", 33'h0, 33'(txDriveEn));
    send(id);
    chk("txDriveEn", 33'h1, 33'(txDriveEn));
    apb(1'b0, hpsd_pkg::OFF_STATUS, 32'h0, status(id, 1'b1, 1'b1, 1'b1));
    idSelectPins <= ~idSelectPins;
    baudFixedPin <= 1'b0;
    rs485Pin <= 1'b0;
    reset(1'b0);
    @(negedge clk);
    chk("unitId", 33'(id), 33'(unitId));
    chk("baudDiv", 33'(hpsd_pkg::USER_DIV_RST), 33'(baudDiv));
    chk("rs485Mode", 33'h0, 33'(rs485Mode));
    chk("txDriveEn", 33'h1, 33'(txDriveEn));
    apb(1'b1, hpsd_pkg::OFF_USER_BAUD, 32'h0000_0341, 33'h0);
    @(posedge clk);
    @(negedge clk);
    chk("baudDiv", 33'h341, 33'(baudDiv));
    reset(1'b1);
    @(negedge clk);
    chk("unitId", 33'(6'({1'b0, idSelectPins}) + 6'h01), 33'(unitId));
    wrap_up();
  end
endmodule
